// file: rtl/audio_clk_monitor.sv
`timescale 1ns/1ps
`include "clkmon_defs.svh"
module audio_clk_monitor
  import clkmon_pkg::*;
#(
  parameter int STOP_CYCLES = `STOP_TIME_US * `CLK_MHZ,
  parameter int HALT_CYCLES = `HALT_TIME_US * `CLK_MHZ
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       primary_ext_bitclk,
  input  wire logic       primary_int_bitclk,
  input  wire logic       primary_fsync_in,
  output logic            primary_fsync_out,
  input  wire logic       secondary_ext_bitclk,
  input  wire logic       secondary_int_bitclk,
  input  wire logic       secondary_fsync_in,
  output logic            secondary_fsync_out,
  input  wire logic       audio_clk_src,
  input  wire logic       rate_conv_ratio_unsupported,
  input  wire logic       custom_ratio_mode,
  input  wire logic       element_matching_rate_bad,
  input  wire logic       mic_clock_bad,
  input  wire logic       refclk_frame_ratio_bad
);
  top_state_t  st;
  top_state_t  next_st;
  logic        clock_stopped;
  logic [7:0]  read_mux;

  port_link_if p_link ();
  port_link_if s_link ();

  // Configuration fields steer the two port units.
  assign p_link.controller = st.p_role;
  assign p_link.int_sel    = st.p_ctrl[`INT_SEL_BIT];
  assign p_link.invert     = st.p_ctrl[`INVERT_BIT];
  assign p_link.ratio      = {st.p_ctrl[`RATIO_HI_MSB:0], st.p_low};
  assign s_link.controller = st.s_role;
  assign s_link.int_sel    = st.s_ctrl[`INT_SEL_BIT];
  assign s_link.invert     = st.s_ctrl[`INVERT_BIT];
  assign s_link.ratio      = {st.s_ctrl[`RATIO_HI_MSB:0], st.s_low};

  port_frame_unit #(
    .HALT_CYCLES (HALT_CYCLES)
  ) u_primary (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .ext_bclk (primary_ext_bitclk),
    .int_bclk (primary_int_bitclk),
    .fsync_in (primary_fsync_in),
    .link     (p_link.unit)
  );

  port_frame_unit #(
    .HALT_CYCLES (HALT_CYCLES)
  ) u_secondary (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .ext_bclk (secondary_ext_bitclk),
    .int_bclk (secondary_int_bitclk),
    .fsync_in (secondary_fsync_in),
    .link     (s_link.unit)
  );

  clk_stop_detect #(
    .STOP_CYCLES (STOP_CYCLES)
  ) u_stop (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .audio_clk (audio_clk_src),
    .stopped   (clock_stopped)
  );

  // Read decode; reserved bits and unmapped offsets read as zero.
  always_comb begin
    case (reg_addr)
      `ADDR_ROLE: begin
        read_mux = 8'h00;
        read_mux[`PROLE_BIT] = st.p_role;
        read_mux[`SROLE_BIT] = st.s_role;
      end
      `ADDR_P_CTRL: begin
        read_mux = st.p_ctrl;
      end
      `ADDR_P_LOW: begin
        read_mux = st.p_low;
      end
      `ADDR_S_CTRL: begin
        read_mux = st.s_ctrl;
      end
      `ADDR_S_LOW: begin
        read_mux = st.s_low;
      end
      `ADDR_STS_A: begin
        read_mux = st.status_a;
      end
      `ADDR_STS_B: begin
        read_mux = st.status_b;
      end
      default: begin
        read_mux = `RD_UNMAPPED;
      end
    endcase
  end

  // Register writes, status tracking and read capture in one next-state process.
  always_comb begin
    next_st = st;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_ROLE: begin
          next_st.p_role = reg_wdata[`PROLE_BIT];
          next_st.s_role = reg_wdata[`SROLE_BIT];
        end
        `ADDR_P_CTRL: begin
          next_st.p_ctrl = reg_wdata;
        end
        `ADDR_P_LOW: begin
          next_st.p_low = reg_wdata;
        end
        `ADDR_S_CTRL: begin
          next_st.s_ctrl = reg_wdata;
        end
        `ADDR_S_LOW: begin
          next_st.s_low = reg_wdata;
        end
        // Writes to the status offsets are dropped, so stray reserved values cannot stick.
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end
    // Flags follow their conditions every cycle; there is nothing for software to clear.
    next_st.status_a = `RST_STS;
    next_st.status_a[`STA_FRAME] = p_link.ratio_fault | s_link.ratio_fault;
    next_st.status_a[`STA_SRC]   = rate_conv_ratio_unsupported & ~custom_ratio_mode;
    next_st.status_a[`STA_DEM]   = element_matching_rate_bad;
    next_st.status_a[`STA_PDM]   = mic_clock_bad;
    next_st.status_a[`STA_STOP]  = clock_stopped;
    next_st.status_b = `RST_STS;
    next_st.status_b[`STB_PRATIO] = p_link.ratio_fault;
    next_st.status_b[`STB_SRATIO] = s_link.ratio_fault;
    next_st.status_b[`STB_REF]    = refclk_frame_ratio_bad;
    next_st.status_b[`STB_PRATE]  = p_link.rate_fault;
    next_st.status_b[`STB_SRATE]  = s_link.rate_fault;
    // Read data is captured on the strobe and holds until the next read.
    if (reg_rd) begin
      next_st.rdata = read_mux;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs come straight from flip-flops here or in the port units.
  assign reg_rdata           = st.rdata;
  assign primary_fsync_out   = p_link.frame;
  assign secondary_fsync_out = s_link.frame;

  // Checks on the flag mapping, the register path and frame generation.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_summary_ratio_flag: assert property (
    ce |=> st.status_a[`STA_FRAME] == $past(p_link.ratio_fault || s_link.ratio_fault))
    else $error("Summary ratio flag does not follow the port ratio faults.");

  a_src_ratio_flag: assert property (
    ce |=> st.status_a[`STA_SRC] == $past(rate_conv_ratio_unsupported && !custom_ratio_mode))
    else $error("Converter ratio flag wrong or not masked by custom ratio mode.");

  a_dem_rate_flag: assert property (
    ce |=> st.status_a[`STA_DEM] == $past(element_matching_rate_bad))
    else $error("Element matching flag does not follow its condition.");

  a_mic_clock_flag: assert property (
    ce |=> st.status_a[`STA_PDM] == $past(mic_clock_bad))
    else $error("Microphone clock flag does not follow its condition.");

  a_stop_flag_map: assert property (
    $rose(st.status_a[`STA_STOP]) |-> $past(clock_stopped) && $past(ce))
    else $error("Clock stop flag rose without the detector.");

  a_primary_ratio_map: assert property (
    ce |=> st.status_b[`STB_PRATIO] == $past(p_link.ratio_fault))
    else $error("Primary ratio flag does not follow the port unit.");

  a_secondary_ratio_map: assert property (
    ce |=> st.status_b[`STB_SRATIO] == $past(s_link.ratio_fault))
    else $error("Secondary ratio flag does not follow the port unit.");

  a_refclk_ratio_map: assert property (
    ce |=> st.status_b[`STB_REF] == $past(refclk_frame_ratio_bad))
    else $error("Reference clock ratio flag does not follow its input.");

  a_primary_rate_map: assert property (
    $rose(st.status_b[`STB_PRATE]) |-> $past(p_link.rate_fault))
    else $error("Primary rate flag rose without a rate fault.");

  a_secondary_rate_map: assert property (
    $fell(st.status_b[`STB_SRATE]) |-> !$past(s_link.rate_fault))
    else $error("Secondary rate flag fell while the fault stood.");

  a_status_write_ignored: assert property (
    (ce && reg_wr && reg_addr == `ADDR_STS_B && !p_link.ratio_fault) |=> !st.status_b[`STB_PRATIO])
    else $error("A host write reached a status flag.");

  a_primary_ratio_read: assert property (
    (ce && reg_rd && reg_addr == `ADDR_P_CTRL) |=> reg_rdata == $past(st.p_ctrl))
    else $error("Primary control read returned the wrong value.");

  a_secondary_ratio_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_S_CTRL) |=> s_link.ratio[13:8] == $past(reg_wdata[5:0]))
    else $error("Secondary high ratio bits did not reach the port unit.");

  a_target_no_frame: assert property (
    (ce && !st.p_role) |=> !primary_fsync_out)
    else $error("Primary frame sync driven while in target role.");

  a_frame_needs_ratio: assert property (
    $rose(primary_fsync_out) |-> $past(st.p_role) && $past(p_link.ratio != '0))
    else $error("Primary frame generated without role or ratio.");

  a_internal_select_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_P_CTRL) |=> p_link.int_sel == $past(reg_wdata[`INT_SEL_BIT]))
    else $error("Primary clock select did not reach the port unit.");

  // Each control and low ratio byte must reach the port units one edge after it is written.
  a_secondary_select_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_S_CTRL) |=> s_link.int_sel == $past(reg_wdata[`INT_SEL_BIT]))
    else $error("Secondary clock select did not reach the port unit.");

  a_primary_invert_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_P_CTRL) |=> p_link.invert == $past(reg_wdata[`INVERT_BIT]))
    else $error("Primary invert bit did not reach the port unit.");

  a_secondary_invert_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_S_CTRL) |=> s_link.invert == $past(reg_wdata[`INVERT_BIT]))
    else $error("Secondary invert bit did not reach the port unit.");

  a_primary_high_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_P_CTRL) |=> p_link.ratio[13:8] == $past(reg_wdata[5:0]))
    else $error("Primary high ratio bits did not reach the port unit.");

  a_primary_low_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_P_LOW) |=> p_link.ratio[7:0] == $past(reg_wdata))
    else $error("Primary low ratio byte did not reach the port unit.");

  a_secondary_low_path: assert property (
    (ce && reg_wr && reg_addr == `ADDR_S_LOW) |=> s_link.ratio[7:0] == $past(reg_wdata))
    else $error("Secondary low ratio byte did not reach the port unit.");

  // Target role and a zero ratio both keep a generator quiet.
  a_secondary_target_quiet: assert property (
    (ce && !st.s_role) |=> !secondary_fsync_out)
    else $error("Secondary frame sync driven while in target role.");

  a_primary_zero_ratio: assert property (
    (ce && p_link.ratio == '0) |=> !primary_fsync_out)
    else $error("Primary frame sync driven with a zero ratio.");

  a_secondary_zero_ratio: assert property (
    (ce && s_link.ratio == '0) |=> !secondary_fsync_out)
    else $error("Secondary frame sync driven with a zero ratio.");

  a_secondary_frame_source: assert property (
    $rose(secondary_fsync_out) |-> $past(st.s_role) && $past(s_link.ratio != '0))
    else $error("Secondary frame generated without role or ratio.");

  // Flags may only move when the condition behind them has moved.
  a_stop_flag_clear: assert property (
    $fell(st.status_a[`STA_STOP]) |-> !$past(clock_stopped))
    else $error("Clock stop flag fell while the detector held it.");

  a_primary_rate_fall: assert property (
    $fell(st.status_b[`STB_PRATE]) |-> !$past(p_link.rate_fault))
    else $error("Primary rate flag fell while the fault stood.");

  a_secondary_rate_rise: assert property (
    $rose(st.status_b[`STB_SRATE]) |-> $past(s_link.rate_fault))
    else $error("Secondary rate flag rose without a rate fault.");

  a_stop_write_ignored: assert property (
    (ce && reg_wr && reg_addr == `ADDR_STS_A && !clock_stopped) |=> !st.status_a[`STA_STOP])
    else $error("A host write reached the clock stop flag.");

  // Reads return the registered value, and the read bus holds between reads.
  a_status_a_read: assert property (
    (ce && reg_rd && reg_addr == `ADDR_STS_A) |=> reg_rdata == $past(st.status_a))
    else $error("Status A read returned the wrong value.");

  a_status_b_read: assert property (
    (ce && reg_rd && reg_addr == `ADDR_STS_B) |=> reg_rdata == $past(st.status_b))
    else $error("Status B read returned the wrong value.");

  a_secondary_low_read: assert property (
    (ce && reg_rd && reg_addr == `ADDR_S_LOW) |=> reg_rdata == $past(st.s_low))
    else $error("Secondary low ratio read returned the wrong value.");

  a_read_data_holds: assert property (
    (ce && !reg_rd) |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

  c_primary_frame: cover property (ce && $rose(primary_fsync_out));
  c_clock_stop: cover property ($rose(st.status_a[`STA_STOP]));
  c_primary_rate_fault: cover property ($rose(st.status_b[`STB_PRATE]));
  c_secondary_frame: cover property (ce && $rose(secondary_fsync_out));
  c_secondary_rate_fault: cover property ($rose(st.status_b[`STB_SRATE]));
endmodule

// file: rtl/clkmon_defs.svh
`ifndef CLKMON_DEFS_SVH
`define CLKMON_DEFS_SVH

// Clock rate and the times that the monitors measure.
`define CLK_MHZ        125
`define STOP_TIME_US   1000
`define HALT_TIME_US   1000
`define CNT_W          17
`define RATIO_W        14

// Register offsets on the control port.
`define ADDR_ROLE      8'h37
`define ADDR_P_CTRL    8'h38
`define ADDR_P_LOW     8'h39
`define ADDR_S_CTRL    8'h3A
`define ADDR_S_LOW     8'h3B
`define ADDR_STS_A     8'h3C
`define ADDR_STS_B     8'h3D

// Field positions.
`define INT_SEL_BIT    7
`define INVERT_BIT     6
`define RATIO_HI_MSB   5
`define PROLE_BIT      4
`define SROLE_BIT      3
`define STA_FRAME      7
`define STA_SRC        4
`define STA_DEM        3
`define STA_PDM        2
`define STA_STOP       1
`define STB_PRATIO     7
`define STB_SRATIO     6
`define STB_REF        5
`define STB_PRATE      4
`define STB_SRATE      3

// Reset values.
`define RST_CFG        8'h00
`define RST_STS        8'h00
`define RD_UNMAPPED    8'h00

`endif

// file: rtl/clkmon_pkg.sv
`include "clkmon_defs.svh"
package clkmon_pkg;
  typedef logic [`RATIO_W-1:0] ratio_t;
  typedef logic [`CNT_W-1:0]   cnt_t;

  typedef struct packed {
    logic   ext_s1;
    logic   ext_s2;
    logic   fs_s1;
    logic   fs_s2;
    logic   gen_prev;
    logic   meas_prev;
    logic   fs_prev;
    logic   frame;
    ratio_t bit_cnt;
    ratio_t meas_cnt;
    ratio_t last_cnt;
    logic [1:0] armed;
    cnt_t   halt_cnt;
    logic   ratio_fault;
    logic   rate_fault;
  } port_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    cnt_t cnt;
    logic stopped;
  } stop_state_t;

  typedef struct packed {
    logic       p_role;
    logic       s_role;
    logic [7:0] p_ctrl;
    logic [7:0] p_low;
    logic [7:0] s_ctrl;
    logic [7:0] s_low;
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] rdata;
  } top_state_t;
endpackage

// file: rtl/port_link_if.sv
`timescale 1ns/1ps
interface port_link_if;
  import clkmon_pkg::*;
  logic   controller;
  logic   int_sel;
  logic   invert;
  ratio_t ratio;
  logic   frame;
  logic   ratio_fault;
  logic   rate_fault;
  modport ctrl (output controller, int_sel, invert, ratio, input frame, ratio_fault, rate_fault);
  modport unit (input controller, int_sel, invert, ratio, output frame, ratio_fault, rate_fault);
endinterface

// file: rtl/port_frame_unit.sv
`timescale 1ns/1ps
`include "clkmon_defs.svh"
module port_frame_unit
  import clkmon_pkg::*;
#(
  parameter int HALT_CYCLES = `HALT_TIME_US * `CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic ext_bclk,
  input  wire logic int_bclk,
  input  wire logic fsync_in,
  port_link_if.unit link
);
  port_state_t st;
  port_state_t next_st;
  logic        sel_bclk;
  logic        gen_clk;
  logic        gen_edge;
  logic        meas_edge;
  logic        fs_obs;
  logic        fs_rise;

  // Generator counts edges of the possibly inverted clock; the monitor always counts true rising edges.
  always_comb begin
    next_st        = st;
    next_st.ext_s1 = ext_bclk;
    next_st.ext_s2 = st.ext_s1;
    next_st.fs_s1  = fsync_in;
    next_st.fs_s2  = st.fs_s1;
    sel_bclk       = link.int_sel ? int_bclk : st.ext_s2;
    gen_clk        = sel_bclk ^ link.invert;
    gen_edge       = gen_clk & ~st.gen_prev;
    meas_edge      = sel_bclk & ~st.meas_prev;
    next_st.gen_prev  = gen_clk;
    next_st.meas_prev = sel_bclk;
    if (!link.controller || link.ratio == '0) begin
      next_st.bit_cnt = '0;
      next_st.frame   = 1'b0;
    end else if (gen_edge) begin
      if (st.bit_cnt >= link.ratio - 14'h1) begin
        next_st.bit_cnt = '0;
        next_st.frame   = 1'b1;
      end else begin
        next_st.bit_cnt = st.bit_cnt + 14'h1;
        next_st.frame   = 1'b0;
      end
    end
    fs_obs          = link.controller ? st.frame : st.fs_s2;
    fs_rise         = fs_obs & ~st.fs_prev;
    next_st.fs_prev = fs_obs;
    if (fs_rise) begin
      next_st.meas_cnt = {13'h0, meas_edge};
      next_st.last_cnt = st.meas_cnt;
      next_st.halt_cnt = '0;
      next_st.armed    = (st.armed == 2'h2) ? 2'h2 : st.armed + 2'h1;
      if (st.armed != 2'h0) begin
        next_st.ratio_fault = (link.ratio != '0) && (st.meas_cnt != link.ratio);
      end
      if (st.armed == 2'h2) begin
        next_st.rate_fault = (st.meas_cnt != st.last_cnt);
      end
    end else begin
      if (meas_edge && st.meas_cnt != '1) begin
        next_st.meas_cnt = st.meas_cnt + 14'h1;
      end
      // A halt is only meaningful once frames have been seen.
      if (st.armed != 2'h0) begin
        if (st.halt_cnt >= `CNT_W'(HALT_CYCLES)) begin
          next_st.rate_fault = 1'b1;
          next_st.armed      = 2'h0;
        end else begin
          next_st.halt_cnt = st.halt_cnt + `CNT_W'(1);
        end
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign link.frame       = st.frame;
  assign link.ratio_fault = st.ratio_fault;
  assign link.rate_fault  = st.rate_fault;
endmodule

// file: rtl/clk_stop_detect.sv
`timescale 1ns/1ps
`include "clkmon_defs.svh"
module clk_stop_detect
  import clkmon_pkg::*;
#(
  parameter int STOP_CYCLES = `STOP_TIME_US * `CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic audio_clk,
  output logic      stopped
);
  stop_state_t st;
  stop_state_t next_st;

  // Any edge of the audio clock restarts the silence count and clears the flag.
  always_comb begin
    next_st      = st;
    next_st.s1   = audio_clk;
    next_st.s2   = st.s1;
    next_st.prev = st.s2;
    if (st.s2 != st.prev) begin
      next_st.cnt     = '0;
      next_st.stopped = 1'b0;
    end else if (st.cnt >= `CNT_W'(STOP_CYCLES)) begin
      next_st.stopped = 1'b1;
    end else begin
      next_st.cnt = st.cnt + `CNT_W'(1);
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign stopped = st.stopped;
endmodule

// file: tb/host_link_model.sv
`timescale 1ns/1ps
// Host side of one serial port: it drives the bit clock and, in target role, the frame sync.
module host_link_model #(
  parameter real HALF = 62.5
) (
  input  wire logic        run,
  input  wire logic        hold,
  input  wire logic [13:0] ratio,
  output logic             bitclk,
  output logic             fsync
);
  logic [13:0] cnt;

  // The clock stands still while idle, and hold stalls the frames.
  // The frame sync moves on the falling edge, so the device sees it settled.
  initial begin
    bitclk = 1'b0;
    fsync  = 1'b0;
    cnt    = 14'h0000;
    forever begin
      #HALF bitclk = run;
      #HALF bitclk = 1'b0;
      if (run) begin
        fsync = (cnt == 14'h0000) && !hold;
        cnt   = (cnt + 14'h0001 >= ratio) ? 14'h0000 : cnt + 14'h0001;
      end else begin
        fsync = 1'b0; // A released port leaves its frame line low.
      end
    end
  end
endmodule

// file: tb/tb_audio_clk_monitor.sv
`timescale 1ns/1ps
`include "clkmon_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t got %0h expected %0h", $time, g, e); end end
module tb_audio_clk_monitor
  import clkmon_pkg::*;
;
  logic            clk, rst, reg_wr, reg_rd, aclk, aclk_run, l0, l1, bad;
  logic [7:0]      reg_addr, reg_wdata, c, d;
  wire logic [7:0] reg_rdata;
  logic [1:0]      ibrun, hrun, hhold;
  logic [1:0]      ibclk = 2'b00;
  wire logic [1:0] ebclk, efs, fso;
  logic [4:0]      lv;
  ratio_t          hratio [2];
  int              n_mismatch, checks_done, cyc, n;
  logic [7:0]      wv [5] = '{8'hFF, 8'hA5, 8'h5A, 8'h3C, 8'hC3};
  logic [7:0]      ev [5] = '{8'h18, 8'hA5, 8'h5A, 8'h3C, 8'hC3};
  logic [4:0]      fl [5] = '{5'b00001, 5'b00011, 5'b00100, 5'b01000, 5'b10000};
  logic [7:0]      fa [5] = '{8'h10, 8'h00, 8'h08, 8'h04, 8'h00};
  logic [7:0]      fb [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20};

  audio_clk_monitor #(.STOP_CYCLES(200), .HALT_CYCLES(400)) u_audio_clk_monitor (
    .clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .primary_ext_bitclk(ebclk[0]), .primary_int_bitclk(ibclk[0]), .primary_fsync_in(efs[0]),
    .primary_fsync_out(fso[0]), .secondary_ext_bitclk(ebclk[1]), .secondary_int_bitclk(ibclk[1]),
    .secondary_fsync_in(efs[1]), .secondary_fsync_out(fso[1]), .audio_clk_src(aclk),
    .rate_conv_ratio_unsupported(lv[0]), .custom_ratio_mode(lv[1]), .element_matching_rate_bad(lv[2]),
    .mic_clock_bad(lv[3]), .refclk_frame_ratio_bad(lv[4])
  );

  // One host model per port; they run only when a test asks for them.
  for (genvar p = 0; p < 2; p++) begin : g_host
    host_link_model u_host (.run(hrun[p]), .hold(hhold[p]), .ratio(hratio[p]), .bitclk(ebclk[p]), .fsync(efs[p]));
  end

  // System clock, 125 MHz.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Audio clock source; its period is kept off the system clock grid on purpose.
  initial begin
    aclk = 1'b0;
    forever #21 if (aclk_run) aclk = ~aclk;
  end

  // Internal bit clocks toggle every system cycle while enabled.
  always @(posedge clk) begin
    ibclk <= ibclk ^ ibrun;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands on the edge that takes the read, so it is sampled just after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v & m, e)
  endtask

  // Cycles between two frame-sync rises, and the internal bit clock level at the first one.
  task automatic meas(input int p, output int per, output logic lvl);
    int k;
    k = 0;
    per = 0;
    for (int s = 0; s < 4; s++) begin
      while (fso[p] !== s[0] && k < 3000) begin
        @(posedge clk);
        #1;
        k++;
      end
      if (s == 1) begin
        lvl = ibclk[p];
        per = k;
      end
    end
    per = k - per;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang counts as a failure and ends the run through the same closing task.
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    aclk_run = 1'b1;
    ibrun = 2'b00;
    hrun = 2'b00;
    hhold = 2'b00;
    lv = 5'b00000;
    hratio = '{14'h0004, 14'h0004};
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h37; a <= 8'h3D; a++) chk_rd(8'(a), 8'hFF, `RST_CFG);
    chk_rd(8'h40, 8'hFF, `RD_UNMAPPED);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) wr(8'(8'h37 + i), wv[i]);
    for (int i = 0; i < 5; i++) chk_rd(8'(8'h37 + i), 8'hFF, ev[i]);
    wr(8'h40, 8'hFF);
    chk_rd(8'h40, 8'hFF, 8'h00);
    for (int i = 0; i < 5; i++) wr(8'(8'h37 + i), 8'h00);
    $display("test register_access done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) lv <= fl[i];
      chk_rd(`ADDR_STS_A, 8'hFF, fa[i]);
      chk_rd(`ADDR_STS_B, 8'hFF, fb[i]);
    end
    @(posedge clk) lv <= 5'b00100;
    wr(`ADDR_STS_A, 8'h9E);
    wr(`ADDR_STS_B, 8'hF8);
    chk_rd(`ADDR_STS_A, 8'hFF, 8'h08);
    chk_rd(`ADDR_STS_B, 8'hFF, 8'h00);
    @(posedge clk) lv <= 5'b00000;
    $display("test fault_flags done");
    @(posedge clk) aclk_run <= 1'b0;
    repeat (150) @(posedge clk);
    chk_rd(`ADDR_STS_A, 8'hFF, 8'h00);
    repeat (100) @(posedge clk);
    chk_rd(`ADDR_STS_A, 8'hFF, 8'h02);
    @(posedge clk) aclk_run <= 1'b1;
    repeat (20) @(posedge clk);
    chk_rd(`ADDR_STS_A, 8'hFF, 8'h00);
    $display("test clock_stop done");
    for (int p = 0; p < 2; p++) begin
      c = 8'(8'h38 + 2 * p);
      wr(`ADDR_ROLE, p ? 8'h08 : 8'h10);
      wr(c + 8'h01, 8'h04);
      wr(c, 8'h80);
      @(posedge clk) ibrun[p] <= 1'b1;
      meas(p, cyc, l0);
      meas(p, cyc, l0);
      `CHK(cyc, 8)
      wr(c, 8'hC0);
      meas(p, cyc, l1);
      meas(p, cyc, l1);
      `CHK(cyc, 8)
      `CHK(l0 ^ l1, 1'b1)
      wr(c, 8'h81);
      wr(c + 8'h01, 8'h00);
      meas(p, cyc, l1);
      meas(p, cyc, l1);
      `CHK(cyc, 512)
      @(posedge clk) ibrun[p] <= 1'b0;
      hrun[p] <= 1'b1;
      wr(c, 8'h00);
      wr(c + 8'h01, 8'h04);
      meas(p, cyc, l1);
      meas(p, cyc, l1);
      `CHK((cyc * 8 + 62) / 125, 4)
      wr(`ADDR_ROLE, 8'h00);
      bad = 1'b0;
      for (int k = 0; k < 200; k++) begin
        @(posedge clk);
        #1;
        if (fso[p] !== 1'b0) bad = 1'b1;
      end
      `CHK(bad, 1'b0)
      @(posedge clk) hrun[p] <= 1'b0;
    end
    $display("test frame_gen done");
    for (int p = 0; p < 2; p++) begin
      c = 8'(8'h39 + 2 * p);
      @(posedge clk) hratio[p] <= 14'h0008;
      hrun[p] <= 1'b1;
      wr(c, 8'h08);
      repeat (700) @(posedge clk);
      chk_rd(`ADDR_STS_B, p ? 8'h48 : 8'h90, 8'h00);
      chk_rd(`ADDR_STS_A, 8'hFF, 8'h00);
      wr(c, 8'h09);
      repeat (300) @(posedge clk);
      chk_rd(`ADDR_STS_B, p ? 8'h40 : 8'h80, p ? 8'h40 : 8'h80);
      chk_rd(`ADDR_STS_A, 8'hFF, 8'h80);
      wr(c, 8'h06);
      @(posedge clk) hratio[p] <= 14'h0006;
      n = 0;
      d = 8'h00;
      while (d[4 - p] !== 1'b1 && n < 300) begin
        rd(`ADDR_STS_B, d);
        n++;
      end
      `CHK(d[4 - p], 1'b1)
      repeat (500) @(posedge clk);
      chk_rd(`ADDR_STS_B, p ? 8'h48 : 8'h90, 8'h00);
      @(posedge clk) hhold[p] <= 1'b1;
      repeat (600) @(posedge clk);
      rd(`ADDR_STS_B, d);
      `CHK(d[4 - p], 1'b1)
      @(posedge clk) hhold[p] <= 1'b0;
      hrun[p] <= 1'b0;
    end
    $display("test frame_monitor done");
    stop_test();
  end
endmodule
